// ==== design/rip_cfg.svh ====
`ifndef RIP_CFG_SVH
`define RIP_CFG_SVH

`define RIP_OFS_PRIO       16'h103C
`define RIP_OFS_CTRL       16'h1040
`define RIP_OFS_MAP        16'h1044
`define RIP_OFS_COND       16'h1048
`define RIP_OFS_STATUS     16'h104C

`define RIP_PR_BOOT        7
`define RIP_PR_SPECIAL     6
`define RIP_PR_MODE_A      5
`define RIP_HP_IRV         4
`define RIP_PSEL_RST       4'h6

`define RIP_CT_IRQE        0
`define RIP_CT_OSC_DELAY   1
`define RIP_CT_CLK_MON     2
`define RIP_CT_CR_LO       3
`define RIP_MAP_RST        8'h01

`define RIP_CC_I           0
`define RIP_CC_X           1
`define RIP_CC_S           2

`define RIP_VEC_NORMAL     16'hFFFE
`define RIP_VEC_SPECIAL    16'hBFFE
`define RIP_VEC_MASK_TOP   16'hFFF2
`define RIP_VEC_NMI_PIN    16'hFFF4
`define RIP_VEC_SOFT       16'hFFF6
`define RIP_VEC_ILL        16'hFFF8

`define RIP_FETCH_CYCLES   2'h3
`define RIP_NUM_MASK       15
`define RIP_NUM_NMI        6

`endif

// ==== design/rip_pkg.sv ====
package rip_pkg;
    typedef enum logic [1:0] {RIP_RESET, RIP_FETCH, RIP_RUN} rip_state_e;
    typedef enum logic [1:0] {RIP_CAUSE_POR, RIP_CAUSE_CLKMON,
                              RIP_CAUSE_WDOG} rip_cause_e;
    typedef logic [3:0] rip_id_t;
endpackage : rip_pkg

// ==== design/rip_arb_if.sv ====
`timescale 1ns/1ps
interface rip_arb_if;
    logic [14:0]        mask_req;
    logic [3:0]         psel;
    logic               mask_valid;
    rip_pkg::rip_id_t   mask_id;
    logic [5:0]         nmi_req;
    logic               nmi_valid;
    logic [2:0]         nmi_id;
    modport ctrl (output mask_req, psel, nmi_req,
                  input mask_valid, mask_id, nmi_valid, nmi_id);
    modport mask (input mask_req, psel, output mask_valid, mask_id);
    modport nmi  (input nmi_req, output nmi_valid, nmi_id);
endinterface : rip_arb_if

// ==== design/rip_nmi_arb.sv ====
`timescale 1ns/1ps
module rip_nmi_arb
(
    rip_arb_if.nmi  arb
);
    function automatic logic [2:0] first_set(input logic [5:0] v);
        first_set = 3'h0;
        for (int i = 5; i >= 0; i--)
        begin
            if (v[i])
            begin
                first_set = 3'(i);
            end
        end
    endfunction : first_set

    // Fixed order, index 0 highest
    assign arb.nmi_valid = |arb.nmi_req; // RULE_14
    assign arb.nmi_id    = first_set(arb.nmi_req); // RULE_14
endmodule : rip_nmi_arb

// ==== design/rip_mask_arb.sv ====
`timescale 1ns/1ps
module rip_mask_arb
(
    input  wire logic   clk,
    input  wire logic   rst,
    rip_arb_if.mask     arb
);
    function automatic rip_pkg::rip_id_t promo_of(input logic [3:0] p);
        if (p >= 4'h8)
            promo_of = 4'(p - 4'h6);
        else if (p <= 4'h4)
            promo_of = 4'(p + 4'hA);
        else if (p == 4'h7)
            promo_of = 4'h1;
        else
            promo_of = 4'h0;
    endfunction : promo_of

    function automatic rip_pkg::rip_id_t first_set(input logic [14:0] v);
        first_set = 4'h0;
        for (int i = 14; i >= 0; i--)
        begin
            if (v[i])
            begin
                first_set = 4'(i); // RULE_15
            end
        end
    endfunction : first_set

    wire rip_pkg::rip_id_t promo = promo_of(arb.psel); // RULE_21
    wire                   promo_hit = arb.mask_req[promo];

    assign arb.mask_valid = |arb.mask_req;
    assign arb.mask_id    = promo_hit ? promo
                                      : first_set(arb.mask_req); // RULE_16

    property p_promo_wins;
        @(posedge clk) disable iff (rst)
        arb.mask_req[promo_of(arb.psel)] |->
            arb.mask_id == promo_of(arb.psel);
    endproperty
    a_promo_wins: assert property (p_promo_wins) // RULE_16
        else $error("promoted source did not win");

    property p_default_order;
        @(posedge clk) disable iff (rst)
        (arb.mask_req[0] && arb.psel == 4'h6) |-> arb.mask_id == 4'h0;
    endproperty
    a_default_order: assert property (p_default_order) // RULE_15
        else $error("external pin lost at default priority");
endmodule : rip_mask_arb

// ==== design/rip_top.sv ====
// How it works
// [RULE_01] Normal modes: reset vector FFFE, FFFC, FFFA
// [RULE_02] Special modes: same order at BF page
// [RULE_03] Three fetch cycles after reset release
// [RULE_04] Reset sets X, I and S
// [RULE_05] Reset loads mapping control with 01
// [RULE_06] Reset loads priority select with 0110
// [RULE_07] External request pin level-sensitive after reset
// [RULE_08] Mode flags latched from pins at release
// [RULE_09] Special mode: writing mode flags changes mode
// [RULE_10] Reset sets oscillator startup delay enable
// [RULE_11] Reset clears clock monitor enable
// [RULE_12] Watchdog reset only when disable bit 0
// [RULE_13] Reset selects shortest watchdog rate
// [RULE_14] Fixed order among six nonmaskable sources
// [RULE_15] Fixed default order of fifteen maskable sources
// [RULE_16] Selected source raised, others keep order
// [RULE_17] Promoted source still gated by masks
// [RULE_18] Every source keeps its own vector
// [RULE_19] Priority register written only while I set
// [RULE_20] Priority register layout, mode-dependent reset
// [RULE_21] Priority select code to source mapping
// [RULE_22] Boot read bit writable only in special
// [RULE_23] Service sets I, X if pin pending
// [RULE_24] Winner resolved combinationally every cycle
`include "rip_cfg.svh"
`timescale 1ns/1ps
module rip_top
(
    input  wire logic           MCLK,
    input  wire logic           SRST,
    input  wire logic           PSEL,
    input  wire logic           PENABLE,
    input  wire logic           PWRITE,
    input  wire logic [15:0]    PADDR,
    input  wire logic [31:0]    PWDATA,
    output logic      [31:0]    PRDATA,
    output logic                PREADY,
    output logic                PSLVERR,
    input  wire logic           MODE_PIN_A,
    input  wire logic           MODE_PIN_B,
    input  wire logic           IRQ_N,
    input  wire logic           NMI_PIN_REQ_N,
    input  wire logic           ILLEGAL_OPCODE,
    input  wire logic           SOFTWARE_INTERRUPT,
    input  wire logic [14:0]    PERIPH_REQ,
    input  wire logic [14:0]    PERIPH_EN,
    input  wire logic           CLOCK_FAIL,
    input  wire logic           WDOG_TIMEOUT,
    input  wire logic           WDOG_DISABLE_BIT,
    input  wire logic           SERVICE_ACK,
    output logic                SYS_RESET_REQ,
    output logic                FETCH_ACTIVE,
    output logic      [15:0]    VECTOR,
    output logic                INT_PENDING,
    output logic      [4:0]     INT_SOURCE,
    output logic      [2:0]     CCR_MASKS,
    output logic      [7:0]     PRIORITY_MISC,
    output logic      [7:0]     RAM_MAP,
    output logic                IRQ_EDGE_MODE,
    output logic                OSC_DELAY_EN,
    output logic                CLOCK_MONITOR_EN,
    output logic      [1:0]     WDOG_RATE
);
    rip_arb_if arb ();

    rip_pkg::rip_state_e    state_reg;
    rip_pkg::rip_cause_e    cause_reg;
    logic [1:0]             cnt_reg;
    logic                   boot_rom_read_flag_reg;
    logic                   special_mode_flag_reg;
    logic                   mda_reg;
    logic                   irv_reg;
    logic [3:0]             psel_reg;
    logic [7:0]             map_reg;
    logic                   irqe_reg;
    logic                   dly_reg;
    logic                   cme_reg;
    logic [1:0]             rate_reg;
    logic                   ccr_i_reg;
    logic                   ccr_x_reg;
    logic                   ccr_s_reg;
    logic                   irq_d_reg;
    logic                   irq_edge_reg;
    logic                   rst_req_reg;
    logic [15:0]            vec_reg;
    logic [31:0]            rdata_reg;

    // Bus decode
    wire wr_acc   = PSEL && PENABLE && PWRITE;
    wire setup    = PSEL && !PENABLE;
    wire hit_hp   = PADDR == `RIP_OFS_PRIO;
    wire hit_ct   = PADDR == `RIP_OFS_CTRL;
    wire hit_map  = PADDR == `RIP_OFS_MAP;
    wire hit_cc   = PADDR == `RIP_OFS_COND;
    wire hit_st   = PADDR == `RIP_OFS_STATUS;
    wire mapped   = hit_hp || hit_ct || hit_map || hit_cc || hit_st;
    wire wr_hp    = wr_acc && hit_hp && ccr_i_reg; // RULE_19
    wire wr_ct    = wr_acc && hit_ct;
    wire wr_map   = wr_acc && hit_map;
    wire wr_cc    = wr_acc && hit_cc;
    wire [7:0] wd = PWDATA[7:0];

    // Interrupt sources
    wire irq_level   = !IRQ_N;
    wire irq_fall    = irq_d_reg && !IRQ_N;
    wire irq_src     = irqe_reg ? irq_edge_reg : irq_level; // RULE_07
    wire [14:0] loc_en = {PERIPH_EN[14:1], 1'b1};
    wire [14:0] m_req = {PERIPH_REQ[14:1], irq_src} & loc_en
                        & {15{!ccr_i_reg}}; // RULE_17
    wire nmi_pin_req = !NMI_PIN_REQ_N && !ccr_x_reg;
    wire clkmon_hit  = CLOCK_FAIL && cme_reg;
    wire wdog_hit    = WDOG_TIMEOUT && !WDOG_DISABLE_BIT; // RULE_12
    wire running     = state_reg == rip_pkg::RIP_RUN;

    assign arb.mask_req = m_req;
    assign arb.psel     = psel_reg;
    assign arb.nmi_req  = {SOFTWARE_INTERRUPT, ILLEGAL_OPCODE, nmi_pin_req,
                           wdog_hit, clkmon_hit, 1'b0}; // RULE_14

    rip_nmi_arb u_nmi
    (
        .arb    (arb.nmi)
    );

    rip_mask_arb u_mask
    (
        .clk    (MCLK),
        .rst    (SRST),
        .arb    (arb.mask)
    );

    // Winner and its fixed vector
    wire nmi_int   = arb.nmi_valid && arb.nmi_id >= 3'h3;
    wire any_int   = running && !rst_req_reg
                     && (nmi_int || arb.mask_valid); // RULE_24
    wire [15:0] mask_vec = 16'(`RIP_VEC_MASK_TOP
                               - {11'h000, arb.mask_id, 1'b0}); // RULE_18
    wire [15:0] nmi_vec  = (arb.nmi_id == 3'h3) ? `RIP_VEC_NMI_PIN :
                           (arb.nmi_id == 3'h4) ? `RIP_VEC_ILL :
                                                  `RIP_VEC_SOFT;
    wire [15:0] int_vec  = nmi_int ? nmi_vec : mask_vec;
    wire take      = SERVICE_ACK && any_int;
    wire take_irq  = take && !nmi_int && arb.mask_id == 4'h0;
    wire take_nmi_pin = take && nmi_int && arb.nmi_id == 3'h3;

    // Reset vector from pins at release and cause
    wire pin_special = !MODE_PIN_B;
    wire [15:0] rst_base = pin_special ? `RIP_VEC_SPECIAL
                                       : `RIP_VEC_NORMAL; // RULE_02
    wire [15:0] rst_vec  = 16'(rst_base - {13'h0000, cause_reg, 1'b0});

    assign INT_PENDING = any_int;
    assign INT_SOURCE  = nmi_int ? {2'h2, arb.nmi_id} : {1'b0, arb.mask_id};

    always_ff @(posedge MCLK)
    begin
        if (SRST)
        begin
            state_reg <= rip_pkg::RIP_RESET;
            cnt_reg   <= 2'h0;
        end
        else if (state_reg == rip_pkg::RIP_RESET)
        begin
            state_reg <= rip_pkg::RIP_FETCH;
        end
        else if (state_reg == rip_pkg::RIP_FETCH)
        begin
            cnt_reg <= 2'(cnt_reg + 2'h1);
            if (cnt_reg == 2'(`RIP_FETCH_CYCLES - 2'h1))
            begin
                state_reg <= rip_pkg::RIP_RUN; // RULE_03
            end
        end
    end

    // Request and cause held through the reset they start
    always_ff @(posedge MCLK)
    begin
        if (SRST)
        begin
            if (rst_req_reg)
                rst_req_reg <= 1'b1;
            else
            begin
                rst_req_reg <= 1'b0;
                cause_reg   <= rip_pkg::RIP_CAUSE_POR;
            end
        end
        else if (state_reg == rip_pkg::RIP_RESET)
        begin
            rst_req_reg <= 1'b0;
        end
        else if (running && !rst_req_reg && arb.nmi_valid && !nmi_int)
        begin
            rst_req_reg <= 1'b1;
            cause_reg   <= rip_pkg::rip_cause_e'(arb.nmi_id[1:0]); // RULE_14
        end
    end

    always_ff @(posedge MCLK)
    begin
        if (SRST)
            vec_reg <= rst_vec; // RULE_01
        else if (take)
            vec_reg <= int_vec; // RULE_23
    end

    // Priority and mode register
    always_ff @(posedge MCLK)
    begin
        if (SRST)
        begin
            special_mode_flag_reg  <= !MODE_PIN_B; // RULE_08
            mda_reg   <= MODE_PIN_A; // RULE_08
            boot_rom_read_flag_reg <= !MODE_PIN_B && !MODE_PIN_A; // RULE_20
            irv_reg   <= !MODE_PIN_B && MODE_PIN_A; // RULE_20
            psel_reg  <= `RIP_PSEL_RST; // RULE_06
        end
        else if (wr_hp)
        begin
            psel_reg <= wd[3:0];
            irv_reg  <= wd[`RIP_HP_IRV];
            if (special_mode_flag_reg)
            begin
                special_mode_flag_reg  <= wd[`RIP_PR_SPECIAL]; // RULE_09
                mda_reg   <= wd[`RIP_PR_MODE_A]; // RULE_09
                boot_rom_read_flag_reg <= wd[`RIP_PR_BOOT] && wd[`RIP_PR_SPECIAL]; // RULE_22
            end
        end
    end

    always_ff @(posedge MCLK)
    begin
        if (SRST)
        begin
            irqe_reg <= 1'b0; // RULE_07
            dly_reg  <= 1'b1; // RULE_10
            cme_reg  <= 1'b0; // RULE_11
            rate_reg <= 2'h0; // RULE_13
            map_reg  <= `RIP_MAP_RST; // RULE_05
        end
        else
        begin
            if (wr_ct)
            begin
                irqe_reg <= wd[`RIP_CT_IRQE];
                dly_reg  <= wd[`RIP_CT_OSC_DELAY];
                cme_reg  <= wd[`RIP_CT_CLK_MON];
                rate_reg <= wd[`RIP_CT_CR_LO +: 2];
            end
            if (wr_map)
                map_reg <= wd;
        end
    end

    // Mask bits: hardware set wins over software clear
    always_ff @(posedge MCLK)
    begin
        if (SRST)
        begin
            ccr_i_reg <= 1'b1; // RULE_04
            ccr_x_reg <= 1'b1; // RULE_04
            ccr_s_reg <= 1'b1; // RULE_04
        end
        else
        begin
            if (wr_cc)
            begin
                ccr_i_reg <= wd[`RIP_CC_I];
                ccr_s_reg <= wd[`RIP_CC_S];
                if (!wd[`RIP_CC_X])
                    ccr_x_reg <= 1'b0;
            end
            if (take)
                ccr_i_reg <= 1'b1; // RULE_23
            if (take_nmi_pin)
                ccr_x_reg <= 1'b1; // RULE_23
        end
    end

    // Edge latch for the external request pin
    always_ff @(posedge MCLK)
    begin
        if (SRST)
        begin
            irq_d_reg    <= 1'b1;
            irq_edge_reg <= 1'b0;
        end
        else
        begin
            irq_d_reg <= IRQ_N;
            if (irq_fall)
                irq_edge_reg <= 1'b1;
            else if (take_irq)
                irq_edge_reg <= 1'b0;
        end
    end

    // Read data captured in the setup phase
    wire [7:0] hp_val = {boot_rom_read_flag_reg && special_mode_flag_reg, special_mode_flag_reg, mda_reg,
                         irv_reg, psel_reg}; // RULE_22
    wire [7:0] ct_val = {3'h0, rate_reg, cme_reg, dly_reg, irqe_reg};
    wire [7:0] st_val = {state_reg, cause_reg, any_int, irq_edge_reg,
                         rst_req_reg, nmi_int};
    wire [7:0] rd_sel = hit_hp  ? hp_val :
                        hit_ct  ? ct_val :
                        hit_map ? map_reg :
                        hit_cc  ? {5'h00, ccr_s_reg, ccr_x_reg, ccr_i_reg} :
                        hit_st  ? st_val : 8'h00;

    always_ff @(posedge MCLK)
    begin
        if (SRST)
            rdata_reg <= 32'h0000_0000;
        else if (setup)
            rdata_reg <= {24'h000000, rd_sel};
    end

    assign PRDATA           = rdata_reg;
    assign PREADY           = 1'b1;
    assign PSLVERR          = PSEL && PENABLE && !mapped;
    assign SYS_RESET_REQ    = rst_req_reg;
    assign FETCH_ACTIVE     = state_reg == rip_pkg::RIP_FETCH;
    assign VECTOR           = vec_reg;
    assign CCR_MASKS        = {ccr_s_reg, ccr_x_reg, ccr_i_reg};
    assign PRIORITY_MISC    = hp_val;
    assign RAM_MAP          = map_reg;
    assign IRQ_EDGE_MODE    = irqe_reg;
    assign OSC_DELAY_EN     = dly_reg;
    assign CLOCK_MONITOR_EN = cme_reg;
    assign WDOG_RATE        = rate_reg;

    property p_fetch_three;
        @(posedge MCLK) disable iff (SRST)
        $fell(SRST) |=> FETCH_ACTIVE [*3] ##1 !FETCH_ACTIVE;
    endproperty
    a_fetch_three: assert property (p_fetch_three) // RULE_03
        else $error("fetch phase is not three cycles");

    property p_vec_normal;
        @(posedge MCLK) disable iff (SRST)
        (FETCH_ACTIVE && !special_mode_flag_reg) |-> VECTOR ==
            16'(`RIP_VEC_NORMAL - {13'h0000, cause_reg, 1'b0});
    endproperty
    a_vec_normal: assert property (p_vec_normal) // RULE_01
        else $error("wrong normal mode reset vector");

    property p_vec_special;
        @(posedge MCLK) disable iff (SRST)
        (FETCH_ACTIVE && special_mode_flag_reg && $past(FETCH_ACTIVE, 1) == 1'b0)
            |-> VECTOR[15:8] == 8'hBF;
    endproperty
    a_vec_special: assert property (p_vec_special) // RULE_02
        else $error("special mode vector not on BF page");

    property p_reset_state;
        @(posedge MCLK)
        SRST |=> (CCR_MASKS == 3'h7 && RAM_MAP == `RIP_MAP_RST
                  && PRIORITY_MISC[3:0] == `RIP_PSEL_RST
                  && OSC_DELAY_EN && !CLOCK_MONITOR_EN
                  && WDOG_RATE == 2'h0 && !IRQ_EDGE_MODE);
    endproperty
    a_reset_state: assert property (p_reset_state) // RULE_04
        else $error("reset state of control bits wrong");

    property p_mode_latch;
        @(posedge MCLK)
        $fell(SRST) |-> (special_mode_flag_reg == !$past(MODE_PIN_B)
                         && mda_reg == $past(MODE_PIN_A));
    endproperty
    a_mode_latch: assert property (p_mode_latch) // RULE_08
        else $error("mode flags not latched at reset release");

    property p_prio_locked;
        @(posedge MCLK) disable iff (SRST)
        (wr_acc && hit_hp && !ccr_i_reg) |=> $stable(PRIORITY_MISC);
    endproperty
    a_prio_locked: assert property (p_prio_locked) // RULE_19
        else $error("priority register written with I clear");

    property p_boot_rom_read_flag_clear;
        @(posedge MCLK) disable iff (SRST)
        !PRIORITY_MISC[`RIP_PR_SPECIAL] |-> !PRIORITY_MISC[`RIP_PR_BOOT];
    endproperty
    a_boot_rom_read_flag_clear: assert property (p_boot_rom_read_flag_clear) // RULE_22
        else $error("boot read bit set outside special mode");

    property p_wdog_off;
        @(posedge MCLK) disable iff (SRST)
        (running && !rst_req_reg && WDOG_DISABLE_BIT && !clkmon_hit)
            |=> !SYS_RESET_REQ;
    endproperty
    a_wdog_off: assert property (p_wdog_off) // RULE_12
        else $error("watchdog reset while disabled");

    property p_i_masks;
        @(posedge MCLK) disable iff (SRST)
        (ccr_i_reg && INT_PENDING) |-> INT_SOURCE[4];
    endproperty
    a_i_masks: assert property (p_i_masks) // RULE_17
        else $error("maskable source offered with I set");

    property p_service_sets_i;
        @(posedge MCLK) disable iff (SRST)
        take |=> (ccr_i_reg && VECTOR == $past(int_vec));
    endproperty
    a_service_sets_i: assert property (p_service_sets_i) // RULE_23
        else $error("service did not set I or load vector");
endmodule : rip_top

// ==== sim/rip_cpu_model.sv ====
`timescale 1ns/1ps
// Processor side: takes the offered interrupt after a chosen latency
module rip_cpu_model
(
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic       ack_en,
    input  wire logic [3:0] lat,
    input  wire logic       pending,
    output logic            ack
);
    logic [3:0] wait_reg;

    // One-cycle acknowledge, never two in a row
    always_ff @(posedge clk)
    begin
        if (rst || !ack_en || !pending || ack)
        begin
            ack      <= 1'b0;
            wait_reg <= 4'h0;
        end
        else if (wait_reg == lat)
            ack <= 1'b1;
        else
            wait_reg <= wait_reg + 4'h1;
    end
endmodule : rip_cpu_model

// ==== sim/tb_top.sv ====
`timescale 1ns/1ps
module tb_top;
    logic        mclk, srst, psel, penable, pwrite, pready, pslverr;
    logic [15:0] paddr, vector;
    logic [31:0] pwdata, prdata, seed, rd;
    logic        mode_a, mode_b, irq_n, nmi_pin_n, ill, sw_int, se, ack_en;
    logic [14:0] preq, pen, act;
    logic        clk_fail, wdog_to, wdog_dis, ack, sys_rst, fetch, int_pend;
    logic [4:0]  int_src;
    logic [2:0]  condition_code_register;
    logic [7:0]  prio, ram_map;
    logic        irq_edge, osc_dly, clock_monitor_enable;
    logic [1:0]  wrate;
    logic [3:0]  lat;
    logic [5:0]  w;
    int          error_cnt, n_compared;

    rip_top dut (.MCLK(mclk), .SRST(srst), .PSEL(psel), .PENABLE(penable),
        .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
        .PREADY(pready), .PSLVERR(pslverr), .MODE_PIN_A(mode_a),
        .MODE_PIN_B(mode_b), .IRQ_N(irq_n), .NMI_PIN_REQ_N(nmi_pin_n),
        .ILLEGAL_OPCODE(ill), .SOFTWARE_INTERRUPT(sw_int), .PERIPH_REQ(preq),
        .PERIPH_EN(pen), .CLOCK_FAIL(clk_fail), .WDOG_TIMEOUT(wdog_to),
        .WDOG_DISABLE_BIT(wdog_dis), .SERVICE_ACK(ack),
        .SYS_RESET_REQ(sys_rst), .FETCH_ACTIVE(fetch), .VECTOR(vector),
        .INT_PENDING(int_pend), .INT_SOURCE(int_src), .CCR_MASKS(condition_code_register),
        .PRIORITY_MISC(prio), .RAM_MAP(ram_map), .IRQ_EDGE_MODE(irq_edge),
        .OSC_DELAY_EN(osc_dly), .CLOCK_MONITOR_EN(clock_monitor_enable), .WDOG_RATE(wrate));

    rip_cpu_model cpu (.clk(mclk), .rst(srst), .ack_en(ack_en), .lat(lat),
        .pending(int_pend), .ack(ack));

    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd

    // Expected {pending, source} for a select code and active requests
    function automatic logic [5:0] win(input logic [3:0] ps,
                                       input logic [14:0] a);
        int p;
        p = (ps == 4'h5 || ps == 4'h6) ? 0 : (ps == 4'h7) ? 1 :
            (ps >= 4'h8) ? int'(ps) - 6 : int'(ps) + 10;
        if (a[p])
            return {1'b1, 5'(p)};
        for (int i = 0; i < 15; i++)
            if (a[i])
                return {1'b1, 5'(i)};
        return 6'h00;
    endfunction : win

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic apb(input logic wr, input logic [15:0] a,
                       input logic [7:0] d);
        @(posedge mclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= {24'h000000, d};
        @(posedge mclk);
        penable <= 1'b1;
        @(posedge mclk);
        while (pready !== 1'b1)
            @(posedge mclk);
        rd = prdata;
        se = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic do_reset(input logic a, input logic b,
                            input logic [15:0] vec);
        @(posedge mclk);
        srst   <= 1'b1;
        mode_a <= a;
        mode_b <= b;
        repeat (8) @(posedge mclk);
        @(negedge mclk);
        chk(vector, vec);
        chk(prio, {!b & !a, !b, a, !b & a, 4'h6});
        chk(condition_code_register, 3'h7);
        chk(ram_map, 8'h01);
        chk({irq_edge, osc_dly, clock_monitor_enable, wrate}, 5'h08);
        @(posedge mclk);
        srst <= 1'b0;
        @(negedge mclk);
        chk(fetch, 1'b0);
        repeat (3)
        begin
            @(negedge mclk);
            chk(fetch, 1'b1);
        end
        @(negedge mclk);
        chk(fetch, 1'b0);
    endtask : do_reset

    task automatic serve(input logic [15:0] vec);
        ack_en <= 1'b1;
        @(posedge mclk);
        for (int i = 0; i < 30 && ack !== 1'b1; i++)
            @(posedge mclk);
        ack_en <= 1'b0;
        @(negedge mclk);
        chk(vector, vec);
        chk(condition_code_register[0], 1'b1);
    endtask : serve

    task automatic fault(input logic cf, input logic wd, input logic exp);
        @(posedge mclk);
        clk_fail <= cf;
        wdog_to  <= wd;
        @(posedge mclk);
        clk_fail <= 1'b0;
        wdog_to  <= 1'b0;
        repeat (2) @(negedge mclk);
        chk(sys_rst, exp);
    endtask : fault

    task close_out;
        $display("compared %0d, errors %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : close_out

    initial
    begin
        mclk = 1'b0;
        forever #25 mclk = ~mclk;
    end

    initial
    begin
        #(50 * 8000);
        error_cnt++;
        close_out();
    end

    initial
    begin
        {srst, mode_a, mode_b} = 3'b100;
        {psel, penable, pwrite, paddr, pwdata} = '0;
        {irq_n, nmi_pin_n, ill, sw_int, preq, pen} = {2'b11, 32'h0};
        {clk_fail, wdog_to, wdog_dis, ack_en, lat} = '0;
        seed = 32'd66;
        error_cnt = 0;
        n_compared = 0;
        for (int m = 0; m < 4; m++)
            do_reset(m[0], m[1], m[1] ? 16'hFFFE : 16'hBFFE);
        apb(1'b0, 16'h1040, 8'h00);
        chk(rd, 32'h02);
        apb(1'b0, 16'h1050, 8'h00);
        chk(se, 1'b1);
        apb(1'b1, 16'h103C, 8'hE6);
        apb(1'b0, 16'h103C, 8'h00);
        chk(rd, 32'h26);
        for (int i = 0; i < 32; i++)
        begin
            @(posedge mclk);
            preq  <= rnd();
            pen   <= rnd();
            irq_n <= rnd() & 1;
            apb(1'b1, 16'h1048, 8'h01);
            apb(1'b1, 16'h103C, {4'h0, 4'(i)});
            @(negedge mclk);
            chk(int_pend, 1'b0);
            apb(1'b1, 16'h1048, 8'h00);
            @(negedge mclk);
            act = {preq[14:1] & pen[14:1], !irq_n};
            w = win(4'(i), act);
            chk(int_pend, w[5]);
            if (w[5])
                chk(int_src, w[4:0]);
        end
        apb(1'b1, 16'h103C, 8'h03);
        apb(1'b0, 16'h103C, 8'h00);
        chk(rd[3:0], 4'hF);
        @(posedge mclk);
        {preq, pen, irq_n, lat} <= {15'h0400, 15'h0400, 1'b1, 4'h3};
        serve(16'hFFDE);
        preq <= 15'h0000;
        apb(1'b1, 16'h1048, 8'h00);
        {nmi_pin_n, ill, sw_int} <= 3'b011;
        @(negedge mclk);
        chk(int_src, 5'd19);
        serve(16'hFFF4);
        chk(condition_code_register[1], 1'b1);
        chk(int_src, 5'd20);
        nmi_pin_n <= 1'b1;
        serve(16'hFFF8);
        ill <= 1'b0;
        @(negedge mclk);
        chk(int_src, 5'd21);
        serve(16'hFFF6);
        sw_int   <= 1'b0;
        wdog_dis <= 1'b1;
        fault(1'b0, 1'b1, 1'b0);
        wdog_dis <= 1'b0;
        fault(1'b0, 1'b1, 1'b1);
        do_reset(1'b1, 1'b1, 16'hFFFA);
        apb(1'b1, 16'h1040, 8'h04);
        fault(1'b1, 1'b1, 1'b1);
        do_reset(1'b0, 1'b0, 16'hBFFC);
        apb(1'b1, 16'h103C, 8'h66);
        apb(1'b0, 16'h103C, 8'h00);
        chk(rd, 32'h66);
        close_out();
    end
endmodule : tb_top
